/* hdl/edge_halver.sv */
// Divide-by-two of a sampled loop-internal signal
`timescale 1ns/1ps
module edge_halver
	import status_mux_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sig,
	output logic half
);

	logic prev_r;
	logic half_r;
	wire rise = sig & ~prev_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev_r <= 1'b0;
			half_r <= 1'b0;
		end
		else
		begin
			prev_r <= sig;
			half_r <= half_r ^ rise;
		end
	end

	assign half = half_r;

endmodule

/* hdl/status_pin_driver.sv */
// Output stage of one status pin: divide-by-4 option and output enable
`timescale 1ns/1ps
module status_pin_driver
	import status_mux_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic level,
	input wire logic out_enable,
	input wire logic div4_enable,
	output logic pin_out,
	output logic pin_oe_n
);

	logic prev_r;
	logic [1:0] div_cnt_r;
	logic pin_out_r;
	logic pin_oe_n_r;
	wire rise = level & ~prev_r;
	wire [1:0] div_cnt_nxt = rise ? 2'(div_cnt_r + 2'h1) : div_cnt_r;
	wire shown = div4_enable ? div_cnt_r[1] : level;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev_r <= 1'b0;
			div_cnt_r <= 2'h0;
			pin_out_r <= 1'b0;
			pin_oe_n_r <= 1'b1;
		end
		else
		begin
			prev_r <= level;
			div_cnt_r <= div_cnt_nxt;
			pin_out_r <= out_enable & shown;
			pin_oe_n_r <= ~out_enable;
		end
	end

	assign pin_out = pin_out_r;
	assign pin_oe_n = pin_oe_n_r;

endmodule

/* hdl/status_pin_monitor_mux.sv */
// Two status pin multiplexers with their selector and pin control registers
`timescale 1ns/1ps

module status_pin_monitor_mux
	import status_mux_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic [15:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	input wire indic_t INDIC,
	input wire loop_dyn_t CLEANUP_DYN,
	input wire loop_dyn_t SYNTH_DYN,
	output logic FIRST_STATUS_PIN_OUT,
	output logic FIRST_STATUS_PIN_OE_N,
	output logic SECOND_STATUS_PIN_OUT,
	output logic SECOND_STATUS_PIN_OE_N
);

	// ************************************************
	// Selection function
	// ************************************************
	function automatic logic pick_level(
		input logic [5:0] code,
		input logic second_pin,
		input indic_t ind,
		input logic [3:0] cleanup_half,
		input logic [3:0] synth_half
	);
		logic lvl;
		lvl = 1'b0;
		case (code)
			CODE_GROUND: lvl = 1'b0;
			CODE_BOTH_LOCKED: lvl = ind.cleanup_locked & ind.synth_locked;
			CODE_CLEANUP_LOCKED: lvl = ind.cleanup_locked;
			CODE_SYNTH_LOCKED: lvl = ind.synth_locked;
			CODE_REFS_MISSING: lvl = ind.first_ref_missing & ind.second_ref_missing;
			CODE_REFS_MISSING_SYNTH_LOCKED:
				lvl = ind.first_ref_missing & ind.second_ref_missing & ind.synth_locked;
			CODE_SECOND_REF_SELECTED: lvl = ind.second_ref_selected;
			CODE_FIRST_REF_VALID: lvl = ind.first_ref_valid;
			CODE_SECOND_REF_VALID: lvl = ind.second_ref_valid;
			CODE_BOTH_REFS_VALID: lvl = ind.first_ref_valid & ind.second_ref_valid;
			CODE_CLEANUP_HOLDOVER: lvl = ind.cleanup_holdover;
			CODE_OSC_VALID: lvl = ind.osc_valid;
			CODE_CLEANUP_FB_VALID: lvl = ind.cleanup_fb_valid;
			CODE_SYNTH_FB_VALID: lvl = ind.synth_fb_valid;
			CODE_FAST_LOCK: lvl = ind.fast_lock_busy;
			CODE_ALL_VALID: lvl = ind.all_valid;
			default:
			begin
				// Loop clocks: cleanup loop on the first pin, synth loop on the second
				if (!second_pin && code >= CODE_CLEANUP_DYN_BASE && code <= CODE_CLEANUP_DYN_LAST)
					lvl = cleanup_half[code[1:0]];
				else if (second_pin && code >= CODE_SYNTH_DYN_BASE && code <= CODE_SYNTH_DYN_LAST)
					lvl = synth_half[code[1:0]];
				else
					lvl = 1'b0;
			end
		endcase
		return lvl;
	endfunction

	// ************************************************
	// Registers
	// ************************************************
	logic [7:0] sel0_r;
	logic [7:0] sel1_r;
	logic [7:0] ctrl_r;
	logic [7:0] rdata_r;

	wire hit_sel0 = REG_ADDR == PIN0_SELECT_OFFSET;
	wire hit_sel1 = REG_ADDR == PIN1_SELECT_OFFSET;
	wire hit_ctrl = REG_ADDR == PIN_CONTROL_OFFSET;
	wire [7:0] sel0_nxt = (REG_WR && hit_sel0) ? REG_WDATA : sel0_r;
	wire [7:0] sel1_nxt = (REG_WR && hit_sel1) ? REG_WDATA : sel1_r;
	wire [7:0] ctrl_nxt = (REG_WR && hit_ctrl) ? (REG_WDATA & PIN_CONTROL_MASK) : ctrl_r;
	// Unmapped addresses read as zero
	wire [7:0] read_mux = hit_sel0 ? sel0_r : hit_sel1 ? sel1_r : hit_ctrl ? ctrl_r : 8'h00;
	wire [7:0] rdata_nxt = REG_RD ? read_mux : rdata_r;

	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			sel0_r <= PIN0_SELECT_RESET;
			sel1_r <= PIN1_SELECT_RESET;
			ctrl_r <= PIN_CONTROL_RESET;
			rdata_r <= 8'h00;
		end
		else
		begin
			sel0_r <= sel0_nxt;
			sel1_r <= sel1_nxt;
			ctrl_r <= ctrl_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign REG_RDATA = rdata_r;

	// ************************************************
	// Halved loop clocks
	// ************************************************
	logic [3:0] cleanup_half;
	logic [3:0] synth_half;

	genvar gi;
	generate
		for (gi = 0; gi < DYN_SIGNALS; gi++)
		begin : g_halve
			edge_halver u_cleanup (
				.clk(CORE_CLK),
				.rst_n(RESETN),
				.sig(CLEANUP_DYN[gi]),
				.half(cleanup_half[gi])
			);
			edge_halver u_synth (
				.clk(CORE_CLK),
				.rst_n(RESETN),
				.sig(SYNTH_DYN[gi]),
				.half(synth_half[gi])
			);
		end
	endgenerate

	// ************************************************
	// Pin selection
	// ************************************************
	// Bits 7:6 of a selector never reach the decode
	pin_cfg_t cfg [STATUS_PINS];
	assign cfg[0] = '{code: sel0_r[SELECT_CODE_LSB +: SELECT_CODE_WIDTH],
		out_enable: ctrl_r[PIN0_OUT_ENABLE_BIT], div4_enable: ctrl_r[PIN0_DIV4_ENABLE_BIT]};
	assign cfg[1] = '{code: sel1_r[SELECT_CODE_LSB +: SELECT_CODE_WIDTH],
		out_enable: ctrl_r[PIN1_OUT_ENABLE_BIT], div4_enable: ctrl_r[PIN1_DIV4_ENABLE_BIT]};

	logic [STATUS_PINS-1:0] level;
	logic [STATUS_PINS-1:0] pin_out;
	logic [STATUS_PINS-1:0] pin_oe_n;

	generate
		for (gi = 0; gi < STATUS_PINS; gi++)
		begin : g_pin
			assign level[gi] = pick_level(cfg[gi].code, 1'(gi), INDIC, cleanup_half, synth_half);
			status_pin_driver u_drv (
				.clk(CORE_CLK),
				.rst_n(RESETN),
				.level(level[gi]),
				.out_enable(cfg[gi].out_enable),
				.div4_enable(cfg[gi].div4_enable),
				.pin_out(pin_out[gi]),
				.pin_oe_n(pin_oe_n[gi])
			);
		end
	endgenerate

	assign FIRST_STATUS_PIN_OUT = pin_out[0];
	assign FIRST_STATUS_PIN_OE_N = pin_oe_n[0];
	assign SECOND_STATUS_PIN_OUT = pin_out[1];
	assign SECOND_STATUS_PIN_OE_N = pin_oe_n[1];

	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);

	wire view0 = cfg[0].out_enable && !cfg[0].div4_enable;
	wire view1 = cfg[1].out_enable && !cfg[1].div4_enable;

	both_lock_a: assert property (view0 && cfg[0].code == CODE_BOTH_LOCKED |=>
		FIRST_STATUS_PIN_OUT == $past(INDIC.cleanup_locked & INDIC.synth_locked))
		else $error("pin0 both-locked view wrong");
	refs_missing_a: assert property (view1 && cfg[1].code == CODE_REFS_MISSING |=>
		SECOND_STATUS_PIN_OUT == $past(INDIC.first_ref_missing & INDIC.second_ref_missing))
		else $error("pin1 refs-missing view wrong");
	miss_lock_a: assert property (view0 && cfg[0].code == CODE_REFS_MISSING_SYNTH_LOCKED &&
		!INDIC.synth_locked |=> !FIRST_STATUS_PIN_OUT)
		else $error("pin0 missing-and-locked high without lock");
	ref_sel_a: assert property (view1 && cfg[1].code == CODE_SECOND_REF_SELECTED |=>
		SECOND_STATUS_PIN_OUT == $past(INDIC.second_ref_selected))
		else $error("pin1 reference-selected view wrong");
	refs_valid_a: assert property (view0 && cfg[0].code == CODE_BOTH_REFS_VALID |=>
		FIRST_STATUS_PIN_OUT == $past(INDIC.first_ref_valid & INDIC.second_ref_valid))
		else $error("pin0 both-refs-valid view wrong");
	holdover_view_a: assert property (view1 && cfg[1].code == CODE_CLEANUP_HOLDOVER |=>
		SECOND_STATUS_PIN_OUT == $past(INDIC.cleanup_holdover))
		else $error("pin1 holdover view wrong");
	synth_fb_a: assert property (view0 && cfg[0].code == CODE_SYNTH_FB_VALID |=>
		FIRST_STATUS_PIN_OUT == $past(INDIC.synth_fb_valid))
		else $error("pin0 synth feedback view wrong");
	fast_lock_a: assert property (view1 && cfg[1].code == CODE_FAST_LOCK |=>
		SECOND_STATUS_PIN_OUT == $past(INDIC.fast_lock_busy))
		else $error("pin1 fast lock view wrong");
	all_valid_a: assert property (view0 && cfg[0].code == CODE_ALL_VALID |=>
		FIRST_STATUS_PIN_OUT == $past(INDIC.all_valid))
		else $error("pin0 all-valid view wrong");
	pin0_half_a: assert property ((view0 && cfg[0].code == CODE_CLEANUP_DYN_BASE && $rose(CLEANUP_DYN.fb_clk))
		##1 (view0 && cfg[0].code == CODE_CLEANUP_DYN_BASE)[*2] |-> FIRST_STATUS_PIN_OUT != $past(FIRST_STATUS_PIN_OUT))
		else $error("pin0 halved feedback clock did not toggle");
	pin1_gnd_a: assert property (cfg[1].code inside {[CODE_CLEANUP_DYN_BASE:CODE_CLEANUP_DYN_LAST]} &&
		!cfg[1].div4_enable |=> !SECOND_STATUS_PIN_OUT)
		else $error("pin1 cleanup-clock codes must drive low");
	pin_disable_a: assert property (!cfg[0].out_enable |=> FIRST_STATUS_PIN_OE_N && !FIRST_STATUS_PIN_OUT)
		else $error("pin0 driven while disabled");
	reserved_low_a: assert property (cfg[0].code > CODE_SYNTH_DYN_LAST && !cfg[0].div4_enable |=>
		!FIRST_STATUS_PIN_OUT)
		else $error("pin0 reserved code not low");

	// Code and pin pairs not watched above, split over both pins so each decoder path is covered
	clean_lock_a: assert property (view0 && cfg[0].code == CODE_CLEANUP_LOCKED |=>
		FIRST_STATUS_PIN_OUT == $past(INDIC.cleanup_locked))
		else $error("pin0 cleanup-locked view wrong");
	synth_lock_a: assert property (view0 && cfg[0].code == CODE_SYNTH_LOCKED |=>
		FIRST_STATUS_PIN_OUT == $past(INDIC.synth_locked))
		else $error("pin0 synth-locked view wrong");
	ground0_a: assert property (cfg[0].code == CODE_GROUND && !cfg[0].div4_enable |=>
		!FIRST_STATUS_PIN_OUT)
		else $error("pin0 ground code not low");
	ground1_a: assert property (cfg[1].code == CODE_GROUND && !cfg[1].div4_enable |=>
		!SECOND_STATUS_PIN_OUT)
		else $error("pin1 ground code not low");
	pin1_lock_a: assert property (view1 && cfg[1].code == CODE_BOTH_LOCKED |=>
		SECOND_STATUS_PIN_OUT == $past(INDIC.cleanup_locked & INDIC.synth_locked))
		else $error("pin1 both-locked view wrong");
	pin0_missing_a: assert property (view0 && cfg[0].code == CODE_REFS_MISSING |=>
		FIRST_STATUS_PIN_OUT == $past(INDIC.first_ref_missing & INDIC.second_ref_missing))
		else $error("pin0 refs-missing view wrong");
	pin1_miss_lock_a: assert property (view1 && cfg[1].code == CODE_REFS_MISSING_SYNTH_LOCKED |=>
		SECOND_STATUS_PIN_OUT == $past(INDIC.first_ref_missing & INDIC.second_ref_missing & INDIC.synth_locked))
		else $error("pin1 missing-and-locked view wrong");
	first_valid_a: assert property (view0 && cfg[0].code == CODE_FIRST_REF_VALID |=>
		FIRST_STATUS_PIN_OUT == $past(INDIC.first_ref_valid))
		else $error("pin0 first-reference-valid view wrong");
	second_valid_a: assert property (view1 && cfg[1].code == CODE_SECOND_REF_VALID |=>
		SECOND_STATUS_PIN_OUT == $past(INDIC.second_ref_valid))
		else $error("pin1 second-reference-valid view wrong");
	osc_valid_a: assert property (view0 && cfg[0].code == CODE_OSC_VALID |=>
		FIRST_STATUS_PIN_OUT == $past(INDIC.osc_valid))
		else $error("pin0 oscillator-valid view wrong");
	clean_fb_a: assert property (view1 && cfg[1].code == CODE_CLEANUP_FB_VALID |=>
		SECOND_STATUS_PIN_OUT == $past(INDIC.cleanup_fb_valid))
		else $error("pin1 cleanup feedback view wrong");
	pin1_synth_fb_a: assert property (view1 && cfg[1].code == CODE_SYNTH_FB_VALID |=>
		SECOND_STATUS_PIN_OUT == $past(INDIC.synth_fb_valid))
		else $error("pin1 synth feedback view wrong");
	pin0_fast_lock_a: assert property (view0 && cfg[0].code == CODE_FAST_LOCK |=>
		FIRST_STATUS_PIN_OUT == $past(INDIC.fast_lock_busy))
		else $error("pin0 fast lock view wrong");
	pin1_all_valid_a: assert property (view1 && cfg[1].code == CODE_ALL_VALID |=>
		SECOND_STATUS_PIN_OUT == $past(INDIC.all_valid))
		else $error("pin1 all-valid view wrong");
	pin0_gnd_a: assert property (cfg[0].code inside {[CODE_SYNTH_DYN_BASE:CODE_SYNTH_DYN_LAST]} &&
		!cfg[0].div4_enable |=> !FIRST_STATUS_PIN_OUT)
		else $error("pin0 synth-clock codes must drive low");
	pin1_half_a: assert property ((view1 && cfg[1].code == CODE_SYNTH_DYN_BASE && $rose(SYNTH_DYN.fb_clk))
		##1 (view1 && cfg[1].code == CODE_SYNTH_DYN_BASE)[*2] |-> SECOND_STATUS_PIN_OUT != $past(SECOND_STATUS_PIN_OUT))
		else $error("pin1 halved feedback clock did not toggle");
	pin1_up_a: assert property ((view1 && cfg[1].code == CODE_SYNTH_DYN_LAST && $rose(SYNTH_DYN.pfd_up))
		##1 (view1 && cfg[1].code == CODE_SYNTH_DYN_LAST)[*2] |-> SECOND_STATUS_PIN_OUT != $past(SECOND_STATUS_PIN_OUT))
		else $error("pin1 halved up pulse did not toggle");
	reserved1_low_a: assert property (cfg[1].code > CODE_SYNTH_DYN_LAST && !cfg[1].div4_enable |=>
		!SECOND_STATUS_PIN_OUT)
		else $error("pin1 reserved code not low");
	pin1_disable_a: assert property (!cfg[1].out_enable |=> SECOND_STATUS_PIN_OE_N && !SECOND_STATUS_PIN_OUT)
		else $error("pin1 driven while disabled");
	pin_drive_a: assert property (cfg[0].out_enable |=>
		!FIRST_STATUS_PIN_OE_N)
		else $error("pin0 not driven while enabled");
	sel0_write_a: assert property (REG_WR && hit_sel0 |=>
		sel0_r == $past(REG_WDATA))
		else $error("pin0 selector write lost");
	sel1_write_a: assert property (REG_WR && hit_sel1 |=>
		sel1_r == $past(REG_WDATA))
		else $error("pin1 selector write lost");

	pin0_lock_c: cover property (view0 && cfg[0].code == CODE_BOTH_LOCKED ##1 FIRST_STATUS_PIN_OUT);
	pin1_synth_c: cover property (view1 && cfg[1].code == CODE_SYNTH_DYN_LAST ##2 $changed(SECOND_STATUS_PIN_OUT));
	pin0_div4_c: cover property (cfg[0].out_enable && cfg[0].div4_enable ##1 $rose(FIRST_STATUS_PIN_OUT));
	pin_off_c: cover property ($rose(SECOND_STATUS_PIN_OE_N));
	pin1_div4_c: cover property (cfg[1].out_enable && cfg[1].div4_enable ##1 $rose(SECOND_STATUS_PIN_OUT));

endmodule

/* shared/status_mux_pkg.sv */
// Package with register map, selector codes and indicator bundles of the status pin multiplexers
package status_mux_pkg;

	// ************************************************
	// Register map
	// ************************************************
	localparam logic [15:0] PIN0_SELECT_OFFSET = 16'h0505;
	localparam logic [15:0] PIN1_SELECT_OFFSET = 16'h0506;
	localparam logic [15:0] PIN_CONTROL_OFFSET = 16'h0507;
	localparam logic [7:0] PIN0_SELECT_RESET = 8'h00;
	localparam logic [7:0] PIN1_SELECT_RESET = 8'h00;
	localparam logic [7:0] PIN_CONTROL_RESET = 8'h00;
	localparam int SELECT_CODE_LSB = 0;
	localparam int SELECT_CODE_WIDTH = 6;
	localparam int PIN1_OUT_ENABLE_BIT = 3;
	localparam int PIN0_OUT_ENABLE_BIT = 2;
	localparam int PIN0_DIV4_ENABLE_BIT = 1;
	localparam int PIN1_DIV4_ENABLE_BIT = 0;
	localparam logic [7:0] PIN_CONTROL_MASK = 8'h0F;

	// ************************************************
	// Selector codes
	// ************************************************
	localparam logic [5:0] CODE_GROUND = 6'h00;
	localparam logic [5:0] CODE_BOTH_LOCKED = 6'h01;
	localparam logic [5:0] CODE_CLEANUP_LOCKED = 6'h02;
	localparam logic [5:0] CODE_SYNTH_LOCKED = 6'h03;
	localparam logic [5:0] CODE_REFS_MISSING = 6'h04;
	localparam logic [5:0] CODE_REFS_MISSING_SYNTH_LOCKED = 6'h05;
	localparam logic [5:0] CODE_SECOND_REF_SELECTED = 6'h06;
	localparam logic [5:0] CODE_FIRST_REF_VALID = 6'h07;
	localparam logic [5:0] CODE_SECOND_REF_VALID = 6'h08;
	localparam logic [5:0] CODE_CLEANUP_HOLDOVER = 6'h09;
	localparam logic [5:0] CODE_OSC_VALID = 6'h0A;
	localparam logic [5:0] CODE_CLEANUP_FB_VALID = 6'h0B;
	localparam logic [5:0] CODE_SYNTH_FB_VALID = 6'h0C;
	localparam logic [5:0] CODE_FAST_LOCK = 6'h0D;
	localparam logic [5:0] CODE_BOTH_REFS_VALID = 6'h0E;
	localparam logic [5:0] CODE_ALL_VALID = 6'h0F;
	localparam logic [5:0] CODE_CLEANUP_DYN_BASE = 6'h10;
	localparam logic [5:0] CODE_CLEANUP_DYN_LAST = 6'h13;
	localparam logic [5:0] CODE_SYNTH_DYN_BASE = 6'h14;
	localparam logic [5:0] CODE_SYNTH_DYN_LAST = 6'h17;
	localparam int DYN_SIGNALS = 4;
	localparam int STATUS_PINS = 2;

	// ************************************************
	// Bundles
	// ************************************************
	typedef struct packed {
		logic cleanup_locked;
		logic synth_locked;
		logic first_ref_missing;
		logic second_ref_missing;
		logic second_ref_selected;
		logic first_ref_valid;
		logic second_ref_valid;
		logic cleanup_holdover;
		logic osc_valid;
		logic cleanup_fb_valid;
		logic synth_fb_valid;
		logic fast_lock_busy;
		logic all_valid;
	} indic_t;

	// Bit order matches code order: feedback, down, reference, up
	typedef struct packed {
		logic pfd_up;
		logic ref_clk;
		logic pfd_down;
		logic fb_clk;
	} loop_dyn_t;

	typedef struct packed {
		logic [5:0] code;
		logic out_enable;
		logic div4_enable;
	} pin_cfg_t;

endpackage

/* test/status_board_model.sv */
// Board-side observer of the two status pins
`timescale 1ns/1ps
module status_board_model
(
	input wire logic core_clk,
	input wire logic s0_out,
	input wire logic s0_oe_n,
	input wire logic s1_out,
	input wire logic s1_oe_n,
	output logic [1:0] pin_level,
	output logic [15:0] edges0,
	output logic [15:0] edges1
);
	logic [1:0] last_r;
	// Board pull-downs hold an undriven pin low
	assign pin_level[0] = s0_oe_n ? 1'b0 : s0_out;
	assign pin_level[1] = s1_oe_n ? 1'b0 : s1_out;
	initial
	begin
		edges0 = '0;
		edges1 = '0;
		last_r = '0;
	end
	// Counting changes lets the bench see a halved or quartered rate
	always @(posedge core_clk)
	begin
		if (pin_level[0] !== last_r[0])
			edges0 <= edges0 + 16'h0001;
		if (pin_level[1] !== last_r[1])
			edges1 <= edges1 + 16'h0001;
		last_r <= pin_level;
	end
endmodule

/* test/tb_top.sv */
// Self-checking bench for the status pin multiplexers
`timescale 1ns/1ps
module tb_top
	import status_mux_pkg::*;
;
	logic core_clk, resetn, reg_wr, reg_rd;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	indic_t indic;
	loop_dyn_t cl_dyn, sy_dyn;
	logic s0_out, s0_oe_n, s1_out, s1_oe_n;
	logic [1:0] lvl;
	logic [15:0] e0, e1, b0, b1;
	int error_cnt = 0;
	int samples_checked = 0;
	indic_t pats[6] = '{13'h1FFF, 13'h0000, 13'h1555, 13'h0AAA, 13'h1600, 13'h0E00};

	status_pin_monitor_mux i_dut (.CORE_CLK(core_clk), .RESETN(resetn), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .INDIC(indic),
		.CLEANUP_DYN(cl_dyn), .SYNTH_DYN(sy_dyn), .FIRST_STATUS_PIN_OUT(s0_out), .FIRST_STATUS_PIN_OE_N(s0_oe_n),
		.SECOND_STATUS_PIN_OUT(s1_out), .SECOND_STATUS_PIN_OE_N(s1_oe_n));
	status_board_model i_board (.core_clk(core_clk), .s0_out(s0_out), .s0_oe_n(s0_oe_n), .s1_out(s1_out),
		.s1_oe_n(s1_oe_n), .pin_level(lvl), .edges0(e0), .edges1(e1));

	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// ************************************************
	// Access and compare tasks
	// ************************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	task automatic settle();
		repeat (3) @(posedge core_clk);
		#1;
	endtask

	function automatic logic exp_lvl(input logic [5:0] c, input indic_t d);
		case (c)
			CODE_BOTH_LOCKED: return d.cleanup_locked & d.synth_locked;
			CODE_CLEANUP_LOCKED: return d.cleanup_locked;
			CODE_SYNTH_LOCKED: return d.synth_locked;
			CODE_REFS_MISSING: return d.first_ref_missing & d.second_ref_missing;
			CODE_REFS_MISSING_SYNTH_LOCKED: return d.first_ref_missing & d.second_ref_missing & d.synth_locked;
			CODE_SECOND_REF_SELECTED: return d.second_ref_selected;
			CODE_FIRST_REF_VALID: return d.first_ref_valid;
			CODE_SECOND_REF_VALID: return d.second_ref_valid;
			CODE_CLEANUP_HOLDOVER: return d.cleanup_holdover;
			CODE_OSC_VALID: return d.osc_valid;
			CODE_CLEANUP_FB_VALID: return d.cleanup_fb_valid;
			CODE_SYNTH_FB_VALID: return d.synth_fb_valid;
			CODE_FAST_LOCK: return d.fast_lock_busy;
			CODE_BOTH_REFS_VALID: return d.first_ref_valid & d.second_ref_valid;
			CODE_ALL_VALID: return d.all_valid;
			default: return 1'b0;
		endcase
	endfunction

	// Toggles the same signal of both loops n times, period of four clocks, and counts pin changes
	task automatic dyn(input logic [7:0] ctrl, input bit pin, input logic [5:0] code, input int n,
		input logic [15:0] exp);
		wr(PIN_CONTROL_OFFSET, ctrl);
		wr(pin ? PIN1_SELECT_OFFSET : PIN0_SELECT_OFFSET, {2'b00, code});
		settle();
		b0 = e0;
		b1 = e1;
		repeat (n)
		begin
			@(posedge core_clk);
			cl_dyn[code[1:0]] <= 1'b1;
			sy_dyn[code[1:0]] <= 1'b1;
			repeat (2) @(posedge core_clk);
			cl_dyn <= '0;
			sy_dyn <= '0;
			@(posedge core_clk);
		end
		settle();
		chk(pin ? e1 - b1 : e0 - b0, exp);
	endtask

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ************************************************
	// Test sequence
	// ************************************************
	initial
	begin
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		indic = '0;
		cl_dyn = '0;
		sy_dyn = '0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		#1 chk({s1_oe_n, s0_oe_n, s1_out, s0_out}, 16'h000C);
		rdchk(PIN0_SELECT_OFFSET, 8'h00);
		rdchk(PIN1_SELECT_OFFSET, 8'h00);
		$display("Test reset values done");
		wr(PIN_CONTROL_OFFSET, 8'hFC);
		rdchk(PIN_CONTROL_OFFSET, 8'h0C);
		wr(16'h0508, 8'hFF);
		rdchk(16'h0508, 8'h00);
		@(posedge core_clk);
		indic <= 13'h1FFF;
		wr(PIN0_SELECT_OFFSET, 8'hC1);
		rdchk(PIN0_SELECT_OFFSET, 8'hC1);
		settle();
		chk(lvl[0], 16'h0001);
		wr(PIN0_SELECT_OFFSET, 8'h3F);
		wr(PIN1_SELECT_OFFSET, 8'h3F);
		settle();
		chk(lvl, 16'h0000);
		$display("Test registers and reserved codes done");
		foreach (pats[p])
			for (int c = 0; c < 16; c++)
			begin
				@(posedge core_clk);
				indic <= pats[p];
				wr(PIN0_SELECT_OFFSET, 8'(c));
				wr(PIN1_SELECT_OFFSET, 8'(15 - c));
				settle();
				chk(lvl[0], exp_lvl(6'(c), pats[p]));
				chk(lvl[1], exp_lvl(6'(15 - c), pats[p]));
			end
		$display("Test static codes done");
		// Both locks high, so a disabled pin that leaks its level would show
		@(posedge core_clk);
		indic <= 13'h1FFF;
		wr(PIN_CONTROL_OFFSET, 8'h08);
		wr(PIN0_SELECT_OFFSET, 8'h01);
		settle();
		chk({s1_oe_n, s0_oe_n, s0_out}, 16'h0002);
		wr(PIN_CONTROL_OFFSET, 8'h04);
		wr(PIN1_SELECT_OFFSET, 8'h01);
		settle();
		chk({s1_oe_n, s0_oe_n, s1_out, s0_out}, 16'h0009);
		$display("Test output enable done");
		for (int c = 16; c < 24; c++)
		begin
			dyn(8'h0C, 1'b0, 6'(c), 8, (c < 20) ? 16'h0008 : 16'h0000);
			dyn(8'h0C, 1'b1, 6'(c), 8, (c < 20) ? 16'h0000 : 16'h0008);
		end
		dyn(8'h0E, 1'b0, 6'h10, 16, 16'h0004);
		dyn(8'h0D, 1'b1, 6'h14, 16, 16'h0004);
		$display("Test halved and quartered clocks done");
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		rdchk(PIN1_SELECT_OFFSET, 8'h00);
		#1 chk({s1_oe_n, s0_oe_n}, 16'h0003);
		$display("Test second reset done");
		close_out();
	end

	// Hang guard
	initial
	begin
		repeat (50000) @(posedge core_clk);
		error_cnt++;
		close_out();
	end
endmodule
